// File: ssf_pkg.sv
package ssf_pkg;

  // ==========================================================================
  // Status register field positions
  // ==========================================================================
  localparam int SSF_SLV_ADDR_LSB   = 1;   // Slave address field 7:1
  localparam int SSF_MST_ADDR_LSB   = 9;   // Master address field 15:9
  localparam int SSF_DONE_BIT       = 24;  // Serial EEPROM init done
  localparam int SSF_NO_ACK_BIT     = 25;  // Unexpected NACK flag
  localparam int SSF_LOST_ARB_BIT   = 26;  // Lost arbitration flag
  localparam int SSF_MISPLACED_BIT  = 27;  // Misplaced START/STOP flag
  localparam int SSF_CHECKSUM_BIT   = 28;  // Init checksum flag
  localparam int SSF_UNMAPPED_BIT   = 29;  // Unmapped register init flag
  localparam int SSF_ERR_LSB        = 25;  // First write-one-to-clear bit

  // ==========================================================================
  // Counts and reset values
  // ==========================================================================
  localparam logic [4:0] SSF_ARB_LIMIT   = 5'h10;  // Consecutive losses to abort
  localparam logic [4:0] SSF_ARB_RESET   = 5'h00;  // Loss counter after reset
  localparam logic [6:0] SSF_ADDR_RESET  = 7'h00;  // Address fields after reset
  localparam logic [4:0] SSF_FLAGS_RESET = 5'h00;  // Error flags after reset
  localparam logic [1:0]  SSF_SETTLE_CYCLES = 2'h2;      // Sync edges before strap capture
  localparam logic [1:0]  SSF_SETTLE_RESET  = 2'h0;      // Settle counter after reset
  localparam logic [13:0] SSF_STRAP_RESET   = 14'h0000;  // Strap sync stages after reset

  // ==========================================================================
  // Types
  // ==========================================================================
  // Error flags in register bit order 25..29
  typedef struct packed {
    logic unmapped_init_attempt;      // Bit 29
    logic init_checksum_error;        // Bit 28
    logic misplaced_condition_error;  // Bit 27
    logic lost_arbitration_error;     // Bit 26
    logic no_ack_error;               // Bit 25
  } ssf_flags_t;

  // Event pulses from the master engine and the EEPROM loader
  typedef struct packed {
    logic unexpected_nack;     // NACK seen in master transaction
    logic arb_lost;            // One arbitration attempt lost
    logic arb_won;             // Arbitration won, streak ends
    logic misplaced_cond;      // START/STOP in wrong place
    logic init_checksum_bad;   // Computed checksum invalid
    logic init_no_done_cmd;    // Image ended without done command
    logic init_unmapped_write; // Write to undefined register
    logic init_finished;       // Loader reached its end
  } ssf_events_t;

  // Whole block state
  typedef struct packed {
    logic [6:0] slave_bus_address;   // Strapped slave address
    logic [6:0] master_bus_address;  // Strapped master address
    logic [13:0] strap_meta;         // Strap pins, first sync stage
    logic [13:0] strap_sync;         // Strap pins, second sync stage
    logic [1:0]  settle_count;       // Edges since reset release
    logic       addr_captured;       // Straps taken after release
    logic       init_done;           // EEPROM init done bit
    ssf_flags_t flags;               // Sticky error flags
    logic [4:0] arb_loss_count;      // Consecutive losses so far
    logic       abort_pulse;         // Transaction abort request
  } ssf_state_t;

endpackage

// File: ssf_status.sv
`timescale 1ns/100ps
// Overview of operation
// [RL1] Slave address read-only in bits 7:1
// [RL2] Master address read-only in bits 15:9
// [RL3] Done bit 24 on init end or error
// [RL4] Unexpected NACK sets bit 25, W1C
// [RL5] Lost arbitration retried automatically by hardware
// [RL6] Sixteen straight losses abort, set bit 26
// [RL7] Misplaced START/STOP sets bit 27, W1C
// [RL8] Bad init checksum sets bit 28, W1C
// [RL9] Missing done command also sets bit 28
// [RL10] Unmapped register init sets bit 29, W1C
// [RL11] Ignore-checksum control suppresses checksum error
// [RL12] Reserved bits zero; writing zero keeps flags
module ssf_status
  import ssf_pkg::*;
(
  input  wire logic        ref_clk,               // Device clock
  input  wire logic        reset,                 // Fundamental reset, async high
  input  wire logic [6:0]  slave_addr_strap,      // Slave address from straps
  input  wire logic [6:0]  master_addr_strap,     // Master address from straps
  input  wire logic        eeprom_init_enable,    // Boot mode loads EEPROM
  input  wire logic        ignore_init_checksum,  // Control bit 17
  input  wire ssf_events_t events,                // Event pulses, same clock
  input  wire logic        status_write,          // Register write strobe
  input  wire logic [31:0] status_wdata,          // Register write data
  output logic [31:0]      smbus_status,          // Register read value
  output logic             arb_retry,             // Rearbitrate request
  output logic             transaction_abort      // Abort after sixteen losses
);

  // ==========================================================================
  // State
  // ==========================================================================
  ssf_state_t state_reg;   // Registered state
  ssf_state_t state_next;  // Next state
  ssf_flags_t set_vec;     // Flags raised this cycle
  ssf_flags_t clr_vec;     // Flags cleared this cycle
  logic       lose_limit;  // This loss is the sixteenth

  // ==========================================================================
  // Next state logic
  // ==========================================================================
  always_comb
  begin
    state_next = state_reg;
    state_next.abort_pulse = 1'b0;
    // Two-stage synchroniser on the strap pins
    state_next.strap_meta = {master_addr_strap, slave_addr_strap};
    state_next.strap_sync = state_reg.strap_meta;
    // Strap capture once, after the synchroniser has settled
    if (!state_reg.addr_captured)
    begin
      if (state_reg.settle_count == SSF_SETTLE_CYCLES)
      begin
        // Settled: take the straps for good
        state_next.slave_bus_address  = state_reg.strap_sync[6:0];   // see [RL1]
        state_next.master_bus_address = state_reg.strap_sync[13:7];  // see [RL2]
        state_next.addr_captured      = 1'b1;
      end
      else
      begin
        // Still settling: one more edge
        state_next.settle_count = state_reg.settle_count + 2'h1;
      end
    end
    // Loss streak counting
    // A win in the same cycle ends the streak instead
    lose_limit = events.arb_lost && !events.arb_won
                 && (state_reg.arb_loss_count == SSF_ARB_LIMIT - 5'h01);
    if (events.arb_won)
    begin
      state_next.arb_loss_count = SSF_ARB_RESET;
    end
    else if (lose_limit)
    begin
      state_next.arb_loss_count = SSF_ARB_RESET;  // see [RL6]
      state_next.abort_pulse    = 1'b1;           // see [RL6]
    end
    else if (events.arb_lost)
    begin
      state_next.arb_loss_count = state_reg.arb_loss_count + 5'h01;  // see [RL5]
    end
    // Event sources
    set_vec.no_ack_error              = events.unexpected_nack;      // see [RL4]
    set_vec.lost_arbitration_error    = lose_limit;                  // see [RL6]
    set_vec.misplaced_condition_error = events.misplaced_cond;       // see [RL7]
    set_vec.init_checksum_error       = (events.init_checksum_bad && !ignore_init_checksum)  // see [RL8] [RL11]
                                        || events.init_no_done_cmd;  // see [RL9]
    set_vec.unmapped_init_attempt     = events.init_unmapped_write;  // see [RL10]
    // Write one clears, zero keeps, set wins
    clr_vec = status_write ? ssf_flags_t'(status_wdata[SSF_UNMAPPED_BIT:SSF_ERR_LSB]) : SSF_FLAGS_RESET;
    state_next.flags = (state_reg.flags & ~clr_vec) | set_vec;  // see [RL12]
    // Done on finish or any init error
    if (eeprom_init_enable && (events.init_finished || set_vec.init_checksum_error
        || events.init_unmapped_write))
    begin
      state_next.init_done = 1'b1;  // see [RL3]
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      // Every field back to its constant
      state_reg <= '{slave_bus_address:  SSF_ADDR_RESET,
                     master_bus_address: SSF_ADDR_RESET,
                     strap_meta:         SSF_STRAP_RESET,
                     strap_sync:         SSF_STRAP_RESET,
                     settle_count:       SSF_SETTLE_RESET,
                     addr_captured:      1'b0,
                     init_done:          1'b0,
                     flags:              SSF_FLAGS_RESET,
                     arb_loss_count:     SSF_ARB_RESET,
                     abort_pulse:        1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Read image, reserved bits zero
  always_comb
  begin
    smbus_status = 32'h0000_0000;  // see [RL12]
    smbus_status[SSF_SLV_ADDR_LSB +: 7] = state_reg.slave_bus_address;   // see [RL1]
    smbus_status[SSF_MST_ADDR_LSB +: 7] = state_reg.master_bus_address;  // see [RL2]
    smbus_status[SSF_DONE_BIT]          = state_reg.init_done;           // see [RL3]
    smbus_status[SSF_UNMAPPED_BIT:SSF_ERR_LSB] = state_reg.flags;
  end

  // Retry after a loss short of the limit
  assign arb_retry         = events.arb_lost && !lose_limit;  // see [RL5]
  assign transaction_abort = state_reg.abort_pulse;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_nack_sets_flag: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL4]
    events.unexpected_nack |=> smbus_status[SSF_NO_ACK_BIT])
    else $error("nack flag not set");
  a_abort_on_limit: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL6]
    (events.arb_lost && state_reg.arb_loss_count == 5'h0f && !events.arb_won)
      |=> transaction_abort && smbus_status[SSF_LOST_ARB_BIT])
    else $error("no abort at sixteenth loss");
  a_retry_early: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL5]
    (events.arb_lost && state_reg.arb_loss_count < 5'h0f) |-> arb_retry)
    else $error("no retry after loss");
  a_misplaced_flag: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL7]
    events.misplaced_cond |=> smbus_status[SSF_MISPLACED_BIT])
    else $error("misplaced flag not set");
  a_checksum_ignored: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL11]
    (ignore_init_checksum && !events.init_no_done_cmd && !smbus_status[SSF_CHECKSUM_BIT])
      |=> !smbus_status[SSF_CHECKSUM_BIT])
    else $error("checksum error despite ignore");
  a_no_done_cmd: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL9]
    events.init_no_done_cmd |=> smbus_status[SSF_CHECKSUM_BIT])
    else $error("missing done command not flagged");
  a_checksum_flag: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL8]
    (events.init_checksum_bad && !ignore_init_checksum) |=> smbus_status[SSF_CHECKSUM_BIT])
    else $error("checksum flag not set");
  a_unmapped_flag: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL10]
    events.init_unmapped_write |=> smbus_status[SSF_UNMAPPED_BIT])
    else $error("unmapped flag not set");
  a_zero_keeps: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL12]
    (status_write && status_wdata[SSF_NO_ACK_BIT] == 1'b0 && smbus_status[SSF_NO_ACK_BIT])
      |=> smbus_status[SSF_NO_ACK_BIT])
    else $error("zero write cleared flag");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL12]
    smbus_status[23:16] == 8'h00 && smbus_status[31:30] == 2'h0 && !smbus_status[0] && !smbus_status[8])
    else $error("reserved bits not zero");
  a_done_sticks: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL3]
    (eeprom_init_enable && events.init_finished) |=> smbus_status[SSF_DONE_BIT] ##1 smbus_status[SSF_DONE_BIT])
    else $error("done bit not held");
  a_addr_stable: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL1]
    state_reg.addr_captured |=> $stable(smbus_status[15:1]))
    else $error("address fields changed");

  // ==========================================================================
  // Assertions: write-one-to-clear behaviour
  // ==========================================================================
  // One clears the nack flag when no new nack arrives
  a_nack_clears: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL4]
    (status_write && status_wdata[SSF_NO_ACK_BIT] && !events.unexpected_nack)
      |=> !smbus_status[SSF_NO_ACK_BIT])
    else $error("nack flag not cleared");
  // One clears the lost arbitration flag
  a_lost_clears: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL6]
    (status_write && status_wdata[SSF_LOST_ARB_BIT] && !lose_limit)
      |=> !smbus_status[SSF_LOST_ARB_BIT])
    else $error("lost arbitration flag not cleared");
  // One clears the misplaced condition flag
  a_misplaced_clears: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL7]
    (status_write && status_wdata[SSF_MISPLACED_BIT] && !events.misplaced_cond)
      |=> !smbus_status[SSF_MISPLACED_BIT])
    else $error("misplaced flag not cleared");
  // One clears the checksum flag
  a_checksum_clears: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL8]
    (status_write && status_wdata[SSF_CHECKSUM_BIT] && !events.init_checksum_bad && !events.init_no_done_cmd)
      |=> !smbus_status[SSF_CHECKSUM_BIT])
    else $error("checksum flag not cleared");
  // One clears the unmapped flag
  a_unmapped_clears: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL10]
    (status_write && status_wdata[SSF_UNMAPPED_BIT] && !events.init_unmapped_write)
      |=> !smbus_status[SSF_UNMAPPED_BIT])
    else $error("unmapped flag not cleared");
  // Event and clear together, the event wins
  a_set_wins: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL12]
    (status_write && status_wdata[SSF_UNMAPPED_BIT] && events.init_unmapped_write)
      |=> smbus_status[SSF_UNMAPPED_BIT])
    else $error("clear beat a new event");

  // ==========================================================================
  // Assertions: flags rise only on their cause
  // ==========================================================================
  // Nack flag stays low without a nack
  a_nack_no_cause: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL4]
    (!smbus_status[SSF_NO_ACK_BIT] && !events.unexpected_nack)
      |=> !smbus_status[SSF_NO_ACK_BIT])
    else $error("nack flag set without cause");
  // Lost arbitration flag only at the sixteenth loss
  a_lost_no_cause: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL6]
    (!smbus_status[SSF_LOST_ARB_BIT] && !lose_limit)
      |=> !smbus_status[SSF_LOST_ARB_BIT])
    else $error("lost arbitration flag set early");
  // Misplaced flag stays low without a misplaced condition
  a_misplaced_no_cause: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL7]
    (!smbus_status[SSF_MISPLACED_BIT] && !events.misplaced_cond)
      |=> !smbus_status[SSF_MISPLACED_BIT])
    else $error("misplaced flag set without cause");
  // Unmapped flag stays low without an unmapped write
  a_unmapped_no_cause: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL10]
    (!smbus_status[SSF_UNMAPPED_BIT] && !events.init_unmapped_write)
      |=> !smbus_status[SSF_UNMAPPED_BIT])
    else $error("unmapped flag set without cause");

  // ==========================================================================
  // Assertions: arbitration streak
  // ==========================================================================
  // No retry once the streak reaches its limit
  a_retry_limit: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL6]
    lose_limit
      |-> !arb_retry)
    else $error("retry at sixteenth loss");
  // Retry only follows a loss
  a_retry_needs_loss: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL5]
    !events.arb_lost
      |-> !arb_retry)
    else $error("retry without loss");
  // Abort is a single cycle pulse
  a_abort_single: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL6]
    transaction_abort
      |=> !transaction_abort)
    else $error("abort longer than one cycle");
  // Abort only after the sixteenth loss
  a_abort_needs_limit: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL6]
    !lose_limit
      |=> !transaction_abort)
    else $error("abort without sixteen losses");
  // A win restarts the streak
  a_win_ends_streak: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL5]
    events.arb_won
      |=> (state_reg.arb_loss_count == SSF_ARB_RESET))
    else $error("streak kept after win");
  // Loss counter never reaches the limit value
  a_count_below_limit: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL6]
    (state_reg.arb_loss_count != SSF_ARB_RESET)
      |-> (state_reg.arb_loss_count < SSF_ARB_LIMIT))
    else $error("loss counter overran");

  // ==========================================================================
  // Assertions: init done and strap capture
  // ==========================================================================
  // Unmapped write ends the load
  a_done_on_unmapped: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL3]
    (eeprom_init_enable && events.init_unmapped_write)
      |=> smbus_status[SSF_DONE_BIT])
    else $error("done not set on unmapped write");
  // Missing done command ends the load
  a_done_on_missing: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL9]
    (eeprom_init_enable && events.init_no_done_cmd)
      |=> smbus_status[SSF_DONE_BIT])
    else $error("done not set on missing command");
  // Done stays low outside EEPROM boot
  a_done_needs_mode: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL3]
    (!eeprom_init_enable && !smbus_status[SSF_DONE_BIT])
      |=> !smbus_status[SSF_DONE_BIT])
    else $error("done set without EEPROM boot");
  // Slave address taken from the settled straps
  a_slave_capture: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL1]
    (!state_reg.addr_captured && state_reg.settle_count == SSF_SETTLE_CYCLES)
      |=> (smbus_status[7:1] == $past(state_reg.strap_sync[6:0])))
    else $error("slave address not captured");
  // Master address taken from the settled straps
  a_master_capture: assert property (@(posedge ref_clk) disable iff (reset)  // see [RL2]
    (!state_reg.addr_captured && state_reg.settle_count == SSF_SETTLE_CYCLES)
      |=> (smbus_status[15:9] == $past(state_reg.strap_sync[13:7])))
    else $error("master address not captured");

endmodule

// File: ssf_bus_partner.sv
`timescale 1ns/100ps
module ssf_bus_partner
  import ssf_pkg::*;
(
  input  wire logic       attempt,  // Master tries for the bus
  input  wire logic       busy,     // Another master holds the bus
  input  wire logic [7:0] req,      // Faults seen on the far side
  output ssf_events_t     events    // Event pulses into the block
);
  // ==========================================================================
  // Contending master and far-side fault reporting
  // ==========================================================================
  // Attempt loses while the rival drives, wins otherwise
  always_comb
  begin
    events          = ssf_events_t'(req);
    events.arb_lost = attempt & busy;
    events.arb_won  = attempt & ~busy;
  end
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top
  import ssf_pkg::*;
  ;
  logic        ref_clk, reset, en, ign, sw, attempt, busy, retry, abort_o;
  logic [6:0]  sa, ma;      // Strap values
  logic [7:0]  req;         // Far-side faults
  logic [31:0] wd, status;  // Write data and read value
  logic [4:0]  fl;          // Expected flags
  logic        done;        // Expected done bit
  ssf_events_t ev;          // Events into the block
  int          failures, checked, seed, run;

  // ==========================================================================
  // Instances and clock
  // ==========================================================================
  ssf_bus_partner partner (.attempt(attempt), .busy(busy), .req(req), .events(ev));
  ssf_status uut (.ref_clk(ref_clk), .reset(reset), .slave_addr_strap(sa), .master_addr_strap(ma),
    .eeprom_init_enable(en), .ignore_init_checksum(ign), .events(ev), .status_write(sw),
    .status_wdata(wd), .smbus_status(status), .arb_retry(retry), .transaction_abort(abort_o));
  initial
  begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Checking helpers
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected register image
  function automatic logic [31:0] exp_status(input logic [4:0] f, input logic d);
    return {2'h0, f, d, 8'h00, ma, 1'h0, sa, 1'h0};
  endfunction
  // One cycle: drive, advance the expected state, compare after the edge
  task automatic step(input logic [7:0] r, input logic a, input logic w, input logic [31:0] d);
    logic lost;
    req = r;
    attempt = a;
    sw = w;
    wd = d;
    lost = a & busy & (run == 15);
    #1;
    if (a) check(retry, busy & ~lost);
    run = !a ? run : (!busy || lost) ? 0 : run + 1;
    fl = (fl & ~(w ? d[29:25] : 5'h00)) | {r[1], r[3] & ~ign | r[2], r[4], lost, r[7]};
    done = done | en & (r[0] | r[1] | r[3] & ~ign | r[2]);
    @(posedge ref_clk);
    #1;
    check(status, exp_status(fl, done));
    check({31'h0, abort_o}, {31'h0, lost});
  endtask
  // Reset pulse, then idle edges while the strap synchroniser settles
  task automatic restart;
    req = 8'h00;
    attempt = 1'b0;
    sw = 1'b0;
    wd = 32'h0;
    reset = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    run = 0;
    fl = 5'h00;
    done = 1'b0;
    repeat (2)
    begin
      @(posedge ref_clk);
      #1;
      check(status, 32'h0000_0000);
    end
  endtask
  task automatic stop_test;
    $display("Counts: checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    seed = 43044;
    failures = 0;
    checked = 0;
    en = 0;
    ign = 0;
    busy = 0;
    sa = 7'($random(seed));
    ma = 7'($random(seed));
    restart();
    step(8'h00, 1'b0, 1'b1, 32'hffff_ffff);
    // Random faults with random clears, ones and zeros alike
    for (int i = 0; i < 300; i++)
    begin
      ign = 1'($random(seed));
      step(8'($random(seed)) & 8'h9e, 1'b0, 1'($random(seed)), 32'($random(seed)));
    end
    // Fifteen losses, a win, then sixteen losses abort
    busy = 1;
    repeat (15) step(8'h00, 1'b1, 1'b0, 32'h0);
    busy = 0;
    step(8'h00, 1'b1, 1'b0, 32'h0);
    busy = 1;
    repeat (16) step(8'h00, 1'b1, 1'b0, 32'h0);
    step(8'h00, 1'b0, 1'b1, 32'h0400_0000);
    // Loader completion with EEPROM boot enabled
    en = 1;
    step(8'h01, 1'b0, 1'b0, 32'h0);
    step(8'h00, 1'b0, 1'b1, 32'h3e00_0000);
    // Mid-run reset with new straps, load ends without done command
    sa = 7'($random(seed));
    ma = 7'($random(seed));
    restart();
    step(8'h04, 1'b0, 1'b0, 32'h0);
    // Ignored bad checksum while the flag is cleared
    ign = 1;
    step(8'h08, 1'b0, 1'b1, 32'h1000_0000);
    stop_test();
  end
  // Watchdog against a hung run
  initial
  begin
    #100000;
    failures++;
    stop_test();
  end
endmodule
